// >>> inc/tcg_map.svh
// register field positions, reset values and counts of the carrier timer
`ifndef TCG_MAP_SVH
`define TCG_MAP_SVH
`define START_BIT 3
`define ENABLE_BIT 2
`define MODE_LO 0
`define CLK_SEL_LO 4
`define CLK_SEL_HI 6
`define MODE_REG_RESET 8'h00
`define COUNT_RESET 8'h00
`define MODULO_RESET 8'hff
`define MODE_EVENT 2'h0
`define MODE_CARRIER 2'h3
`define READ_HOLD_CYCLES 4'h1
`endif

// >>> inc/tcg_pkg.sv
// types of the carrier timer
package tcg_pkg;
	typedef enum logic [2:0] {
		IDLE = 3'b001,
		WAIT_EDGE = 3'b010,
		FOLLOW = 3'b100
	} gate_state_type;
	typedef logic [7:0] byte_type;
endpackage

// >>> rtl/tcg_channel.sv
// one 8-bit timer channel: count pulse select, count, match, start clear
`timescale 1ns/1ps
`default_nettype none
`include "tcg_map.svh"
module tcg_channel
	import tcg_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// configuration
	input wire logic [7:0] mode,
	input wire logic mode_wr,
	input wire logic [WIDTH-1:0] modulo,
	input wire logic [WIDTH-1:0] high_modulo,
	// count pulse sources, already synchronised
	input wire logic [7:0] pulse_src,
	input wire logic read_hold,
	input wire logic irq_clear,
	// results
	output logic [WIDTH-1:0] count,
	output logic irq,
	output logic tout,
	output logic match_pulse
);
	logic [WIDTH-1:0] next_count;
	logic next_irq, next_tout, next_match, cp;
	logic start, run, hit_mod, hit_high, carrier;
	always_comb
	begin
		start = mode_wr && mode[`START_BIT];
		run = mode[`ENABLE_BIT];
		carrier = mode[1:0] == `MODE_CARRIER;
		// new source used at once; external gated during a read
		cp = pulse_src[mode[`CLK_SEL_HI:`CLK_SEL_LO]] && !read_hold;
		hit_mod = count == modulo;
		hit_high = carrier && count == high_modulo;
		next_count = count;
		next_irq = irq && !irq_clear;
		next_tout = tout;
		next_match = 1'b0;
		if (run && cp)
		begin
			// match returns to zero; overflow wraps to zero too
			if (hit_mod)
				next_count = '0;
			else
				next_count = count + 1'b1;
			if (hit_mod)
			begin
				next_irq = 1'b1;
				next_match = 1'b1;
				next_tout = ~tout;
			end
			else if (hit_high)
				next_tout = ~tout;
		end
		// start clears on the system clock, not the pulse
		if (start)
		begin
			next_count = '0;
			next_tout = 1'b0;
			if (!next_match)
				next_irq = 1'b0;
		end
	end
	// register the channel state
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count <= `COUNT_RESET;
			irq <= 1'b0;
			tout <= 1'b0;
			match_pulse <= 1'b0;
		end
		else
		begin
			count <= next_count;
			irq <= next_irq;
			tout <= next_tout;
			match_pulse <= next_match;
		end
	end
	a_start_clears: assert property (@(posedge clk) disable iff (!reset_n)
		start && !next_match |=> count == '0 && !irq)
		else $error("start did not clear count and flag");
	a_hit_sets_irq: assert property (@(posedge clk) disable iff (!reset_n)
		run && cp && hit_mod |=> irq && match_pulse)
		else $error("match did not set flag");
	a_hold_freezes: assert property (@(posedge clk) disable iff (!reset_n)
		read_hold && !start |=> count == $past(count))
		else $error("count moved during read");
	a_match_wraps: assert property (@(posedge clk) disable iff (!reset_n)
		run && cp && hit_mod && !start |=> count == '0)
		else $error("count not zero after match");
	c_match: cover property (@(posedge clk) disable iff (!reset_n) match_pulse);
	c_start_hit: cover property (@(posedge clk) disable iff (!reset_n)
		start && run && cp && hit_mod);
endmodule
`default_nettype wire

// >>> rtl/tcg_top.sv
// carrier generator: event timer, carrier timer and level-select gating
`timescale 1ns/1ps
`default_nettype none
`include "tcg_map.svh"
//
// Function
// - start clears count asynchronously to pulse
// - slow pulse start error up to one pulse period
// - start clears count and interrupt flag
// - coincident match may leave flag set
// - count readable any time, held during read with external source
// - external pulse blocked while reading
// - new pulse selection effective immediately
// - low modulo: count overflows, restarts zero
// - first carrier low carries start error
// - carrier after reload delayed one period
// - output waits for carrier boundary
// - channel one interrupt reloads level flag
// - zero control write clears buffer, flag
// - mode pattern starts event counter mode
// - output carrier (remote flag) or steady high when level one, else low
// - high and low modulo matches toggle output
module tcg_top
	import tcg_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// channel 1 configuration
	input wire logic [7:0] CH1_MODE_REG,
	input wire logic CH1_MODE_WR,
	input wire logic [WIDTH-1:0] CH1_MODULO_REG,
	input wire logic CH1_IRQ_CLEAR,
	// channel 2 configuration
	input wire logic [7:0] CH2_MODE_REG,
	input wire logic CH2_MODE_WR,
	input wire logic [WIDTH-1:0] MODULO_REG,
	input wire logic [WIDTH-1:0] HIGH_PERIOD_MODULO_REG,
	input wire logic CH2_IRQ_CLEAR,
	// carrier control and level select
	input wire logic [7:0] CARRIER_CONTROL_REG,
	input wire logic CARRIER_CONTROL_WR,
	input wire logic LEVEL_BUFFER_WR,
	input wire logic LEVEL_BUFFER_VALUE,
	input wire logic LEVEL_FLAG_WR,
	input wire logic LEVEL_FLAG_VALUE,
	input wire logic REMOTE_OUTPUT_CTRL_FLAG,
	// count pulse sources and read strobes
	input wire logic [7:0] PRESCALE_PULSES,
	input wire logic EXTERNAL_COUNT_INPUT,
	input wire logic CH1_READ,
	input wire logic CH2_READ,
	// status and output
	output logic [WIDTH-1:0] CH1_COUNT,
	output logic [WIDTH-1:0] CH2_COUNT,
	output logic CH1_IRQ_FLAG,
	output logic CH2_IRQ_FLAG,
	output logic LEVEL_SELECT_BUFFER,
	output logic LEVEL_SELECT_FLAG,
	output logic CARRIER_OUTPUT_PIN
);
	logic ext_meta, ext_sync, ext_prev, ext_edge;
	logic [7:0] src1, src2;
	logic [WIDTH-1:0] count1, count2;
	logic irq1, irq2, tout2, match1;
	logic level_gated, next_level_gated, next_pin;
	logic level_buf, next_level_buf, level_flag, next_level_flag;
	gate_state_type state, next_state;
	// external input: two flops, then rising edge detect
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end
		else
		begin
			ext_meta <= EXTERNAL_COUNT_INPUT;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end
	// source 7 is the external edge; reads gate only that source
	always_comb
	begin
		ext_edge = ext_sync && !ext_prev;
		src1 = {ext_edge, PRESCALE_PULSES[6:0]};
		src2 = {ext_edge, PRESCALE_PULSES[6:0]};
	end
	// channel 1 event counter, runs the mode pattern written
	tcg_channel #(.WIDTH(WIDTH)) u_ch1 (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.mode(CH1_MODE_REG),
		.mode_wr(CH1_MODE_WR),
		.modulo(CH1_MODULO_REG),
		.high_modulo(CH1_MODULO_REG),
		.pulse_src(src1),
		.read_hold(CH1_READ && CH1_MODE_REG[7:4] == 4'h7),
		.irq_clear(CH1_IRQ_CLEAR),
		.count(count1),
		.irq(irq1),
		.tout(),
		.match_pulse(match1)
	);
	// channel 2 carrier clock generator
	tcg_channel #(.WIDTH(WIDTH)) u_ch2 (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.mode(CH2_MODE_REG),
		.mode_wr(CH2_MODE_WR),
		.modulo(MODULO_REG),
		.high_modulo(HIGH_PERIOD_MODULO_REG),
		.pulse_src(src2),
		.read_hold(CH2_READ && CH2_MODE_REG[7:4] == 4'h7),
		.irq_clear(CH2_IRQ_CLEAR),
		.count(count2),
		.irq(irq2),
		.tout(tout2),
		.match_pulse()
	);
	// level buffer and flag: reload on channel 1 match
	always_comb
	begin
		next_level_buf = level_buf;
		next_level_flag = level_flag;
		if (LEVEL_BUFFER_WR)
			next_level_buf = LEVEL_BUFFER_VALUE;
		if (LEVEL_FLAG_WR)
			next_level_flag = LEVEL_FLAG_VALUE;
		if (match1)
			next_level_flag = level_buf;
		if (CARRIER_CONTROL_WR && CARRIER_CONTROL_REG == 8'h00)
		begin
			next_level_buf = 1'b0;
			next_level_flag = 1'b0;
		end
	end
	// gated level follows the flag only at a carrier boundary
	always_comb
	begin
		next_state = state;
		next_level_gated = level_gated;
		unique case (state)
			IDLE:
				if (level_flag != level_gated)
					next_state = WAIT_EDGE;
			WAIT_EDGE:
				// rise waits for carrier high, fall for carrier low
				if (tout2 == level_flag)
				begin
					next_level_gated = level_flag;
					next_state = FOLLOW;
				end
				else if (level_flag == level_gated)
					next_state = IDLE;
			FOLLOW:
				next_state = IDLE;
			default:
				next_state = IDLE;
		endcase
		// remote control flag chooses carrier or steady high
		if (!level_gated)
			next_pin = 1'b0;
		else if (REMOTE_OUTPUT_CTRL_FLAG)
			next_pin = tout2 || !CH2_MODE_REG[`ENABLE_BIT];
		else
			next_pin = 1'b1;
	end
	// register level state and all outputs
	always_ff @(posedge CLK_SYS or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			level_buf <= 1'b0;
			level_flag <= 1'b0;
			level_gated <= 1'b0;
			state <= IDLE;
			CARRIER_OUTPUT_PIN <= 1'b0;
			CH1_COUNT <= '0;
			CH2_COUNT <= '0;
			CH1_IRQ_FLAG <= 1'b0;
			CH2_IRQ_FLAG <= 1'b0;
			LEVEL_SELECT_BUFFER <= 1'b0;
			LEVEL_SELECT_FLAG <= 1'b0;
		end
		else
		begin
			level_buf <= next_level_buf;
			level_flag <= next_level_flag;
			level_gated <= next_level_gated;
			state <= next_state;
			CARRIER_OUTPUT_PIN <= next_pin;
			CH1_COUNT <= count1;
			CH2_COUNT <= count2;
			CH1_IRQ_FLAG <= irq1;
			CH2_IRQ_FLAG <= irq2;
			LEVEL_SELECT_BUFFER <= level_buf;
			LEVEL_SELECT_FLAG <= level_flag;
		end
	end
	a_reload_flag: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		match1 && !LEVEL_FLAG_WR && !CARRIER_CONTROL_WR
		|=> level_flag == $past(level_buf))
		else $error("level flag not reloaded from buffer");
	a_zero_clears: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		CARRIER_CONTROL_WR && CARRIER_CONTROL_REG == 8'h00
		|=> !level_buf && !level_flag)
		else $error("zero control write did not clear level bits");
	a_low_when_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		!level_gated |=> !CARRIER_OUTPUT_PIN)
		else $error("pin high while level is zero");
	a_rise_on_high: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		$rose(level_gated) |-> $past(tout2))
		else $error("level rose away from carrier boundary");
	c_reload: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		match1 && level_buf);
	c_carrier_out: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		level_gated && REMOTE_OUTPUT_CTRL_FLAG && $rose(tout2));
	c_gate_wait: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
		state == WAIT_EDGE ##1 state == FOLLOW);
endmodule
`default_nettype wire

// >>> test/tb_tcg_top.sv
// self-checking bench for the carrier timer top level
`timescale 1ns/1ps
`default_nettype none
module tb_tcg_top import tcg_pkg::*;;
	logic CLK_SYS = 1'b0;
	logic RESET_N = 1'b0;
	logic [7:0] CH1_MODE_REG = 8'h00;
	logic [7:0] CH2_MODE_REG = 8'h00;
	logic [7:0] CH1_MODULO_REG = 8'hff;
	logic [7:0] MODULO_REG = 8'hff;
	logic [7:0] HIGH_PERIOD_MODULO_REG = 8'hff;
	logic [7:0] CARRIER_CONTROL_REG = 8'h00;
	logic [7:0] PRESCALE_PULSES = 8'h7f;
	logic CH1_MODE_WR = 1'b0;
	logic CH2_MODE_WR = 1'b0;
	logic CH1_IRQ_CLEAR = 1'b0;
	logic CH2_IRQ_CLEAR = 1'b0;
	logic CARRIER_CONTROL_WR = 1'b0;
	logic LEVEL_BUFFER_WR = 1'b0;
	logic LEVEL_BUFFER_VALUE = 1'b0;
	logic LEVEL_FLAG_WR = 1'b0;
	logic LEVEL_FLAG_VALUE = 1'b0;
	logic REMOTE_OUTPUT_CTRL_FLAG = 1'b0;
	logic EXTERNAL_COUNT_INPUT = 1'b0;
	logic CH1_READ = 1'b0;
	logic CH2_READ = 1'b0;
	byte_type CH1_COUNT;
	byte_type CH2_COUNT;
	logic CH1_IRQ_FLAG;
	logic CH2_IRQ_FLAG;
	logic LEVEL_SELECT_BUFFER;
	logic LEVEL_SELECT_FLAG;
	logic CARRIER_OUTPUT_PIN;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int i;
	int t;
	tcg_top tcg_top_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
		.CH1_MODE_REG(CH1_MODE_REG), .CH1_MODE_WR(CH1_MODE_WR),
		.CH1_MODULO_REG(CH1_MODULO_REG), .CH1_IRQ_CLEAR(CH1_IRQ_CLEAR),
		.CH2_MODE_REG(CH2_MODE_REG), .CH2_MODE_WR(CH2_MODE_WR),
		.MODULO_REG(MODULO_REG),
		.HIGH_PERIOD_MODULO_REG(HIGH_PERIOD_MODULO_REG),
		.CH2_IRQ_CLEAR(CH2_IRQ_CLEAR),
		.CARRIER_CONTROL_REG(CARRIER_CONTROL_REG),
		.CARRIER_CONTROL_WR(CARRIER_CONTROL_WR),
		.LEVEL_BUFFER_WR(LEVEL_BUFFER_WR),
		.LEVEL_BUFFER_VALUE(LEVEL_BUFFER_VALUE),
		.LEVEL_FLAG_WR(LEVEL_FLAG_WR), .LEVEL_FLAG_VALUE(LEVEL_FLAG_VALUE),
		.REMOTE_OUTPUT_CTRL_FLAG(REMOTE_OUTPUT_CTRL_FLAG),
		.PRESCALE_PULSES(PRESCALE_PULSES),
		.EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT),
		.CH1_READ(CH1_READ), .CH2_READ(CH2_READ),
		.CH1_COUNT(CH1_COUNT), .CH2_COUNT(CH2_COUNT),
		.CH1_IRQ_FLAG(CH1_IRQ_FLAG), .CH2_IRQ_FLAG(CH2_IRQ_FLAG),
		.LEVEL_SELECT_BUFFER(LEVEL_SELECT_BUFFER),
		.LEVEL_SELECT_FLAG(LEVEL_SELECT_FLAG),
		.CARRIER_OUTPUT_PIN(CARRIER_OUTPUT_PIN));
	// 250 MHz system clock
	always #2 CLK_SYS = ~CLK_SYS;
	// hang guard
	always @(posedge CLK_SYS)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			$display("[FAIL] %0t timeout", $time);
			n_fail++;
			end_sim();
		end
	end
	task tick(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask
	task chk8(input byte_type got, input byte_type exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t count %h want %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t bit %b want %b", $time, got, exp);
		end
	endtask
	// one-cycle mode write on channel 1 or 2
	task wr(input bit ch, input logic [7:0] m);
		if (ch)
		begin
			CH2_MODE_REG = m;
			CH2_MODE_WR = 1'b1;
			tick(1);
			CH2_MODE_WR = 1'b0;
		end
		else
		begin
			CH1_MODE_REG = m;
			CH1_MODE_WR = 1'b1;
			tick(1);
			CH1_MODE_WR = 1'b0;
		end
	endtask
	// wide pulses on the event input
	task ext(input int n);
		repeat (n)
		begin
			EXTERNAL_COUNT_INPUT = 1'b1;
			tick(4);
			EXTERNAL_COUNT_INPUT = 1'b0;
			tick(4);
		end
	endtask
	task wait_irq1();
		for (i = 0; i < 60 && CH1_IRQ_FLAG !== 1'b1; i++) tick(1);
	endtask
	// match, wrap to zero, restart clears
	task t_start();
		CH1_MODULO_REG = 8'h04;
		wr(0, 8'h6c);
		wait_irq1();
		chk1(CH1_IRQ_FLAG, 1'b1);
		chk8(CH1_COUNT, 8'h00);
		tick(1);
		chk8(CH1_COUNT, 8'h01);
		wr(0, 8'h6c);
		tick(1);
		chk8(CH1_COUNT, 8'h00);
		chk1(CH1_IRQ_FLAG, 1'b0);
		// start lands on the match edge, then start again
		tick(3);
		wr(0, 8'h6c);
		tick(1);
		chk1(CH1_IRQ_FLAG, 1'b1);
		chk8(CH1_COUNT, 8'h00);
		wr(0, 8'h6c);
		tick(1);
		chk1(CH1_IRQ_FLAG, 1'b0);
	endtask
	// event source frozen while a read is in progress
	task t_read();
		CH1_MODULO_REG = 8'h10;
		wr(0, 8'h7c);
		CH1_READ = 1'b1;
		ext(3);
		tick(6);
		chk8(CH1_COUNT, 8'h00);
		CH1_READ = 1'b0;
		ext(3);
		tick(6);
		chk8(CH1_COUNT, 8'h03);
	endtask
	// modulo lowered below the count
	task t_modulo();
		CH1_MODULO_REG = 8'hf0;
		wr(0, 8'h6c);
		for (i = 0; i < 100 && CH1_COUNT !== 8'h20; i++) tick(1);
		CH1_MODULO_REG = 8'h10;
		for (i = 0; i < 300 && CH1_COUNT !== 8'hff; i++) tick(1);
		chk8(CH1_COUNT, 8'hff);
		chk1(CH1_IRQ_FLAG, 1'b0);
		wait_irq1();
		chk1(CH1_IRQ_FLAG, 1'b1);
		chk8(CH1_COUNT, 8'h00);
		wr(0, 8'h6c);
		tick(1);
		chk8(CH1_COUNT, 8'h00);
	endtask
	// level reload and carrier gating
	task t_carrier();
		LEVEL_FLAG_VALUE = 1'b1;
		LEVEL_FLAG_WR = 1'b1;
		LEVEL_BUFFER_VALUE = 1'b1;
		LEVEL_BUFFER_WR = 1'b1;
		tick(1);
		LEVEL_FLAG_WR = 1'b0;
		LEVEL_BUFFER_WR = 1'b0;
		CARRIER_CONTROL_WR = 1'b1;
		tick(1);
		CARRIER_CONTROL_WR = 1'b0;
		tick(2);
		chk1(LEVEL_SELECT_BUFFER, 1'b0);
		chk1(LEVEL_SELECT_FLAG, 1'b0);
		HIGH_PERIOD_MODULO_REG = 8'h02;
		MODULO_REG = 8'h05;
		REMOTE_OUTPUT_CTRL_FLAG = 1'b1;
		wr(1, 8'h6f);
		tick(3);
		chk8(CH2_COUNT, 8'h02);
		CH1_MODULO_REG = 8'h20;
		wr(0, 8'h6c);
		LEVEL_BUFFER_VALUE = 1'b1;
		LEVEL_BUFFER_WR = 1'b1;
		tick(1);
		LEVEL_BUFFER_WR = 1'b0;
		wait_irq1();
		tick(7);
		chk1(LEVEL_SELECT_FLAG, 1'b1);
		t = 0;
		for (i = 0; i < 48; i++)
		begin
			tick(1);
			if (CARRIER_OUTPUT_PIN === 1'b1) t++;
		end
		chk1(t == 24, 1'b1);
		chk1(CH2_IRQ_FLAG, 1'b1);
		CH1_IRQ_CLEAR = 1'b1;
		LEVEL_BUFFER_VALUE = 1'b0;
		LEVEL_BUFFER_WR = 1'b1;
		tick(1);
		CH1_IRQ_CLEAR = 1'b0;
		LEVEL_BUFFER_WR = 1'b0;
		// registered flag lags the clear by one cycle
		tick(1);
		wait_irq1();
		tick(12);
		t = 0;
		for (i = 0; i < 20; i++)
		begin
			tick(1);
			if (CARRIER_OUTPUT_PIN !== 1'b0) t++;
		end
		chk1(LEVEL_SELECT_FLAG, 1'b0);
		chk1(t == 0, 1'b1);
	endtask
	task end_sim();
		$display("checks %0d failures %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial
	begin
		tick(8);
		RESET_N = 1'b1;
		tick(1);
		chk8(CH1_COUNT, 8'h00);
		chk1(CARRIER_OUTPUT_PIN, 1'b0);
		t_start();
		t_read();
		t_modulo();
		t_carrier();
		end_sim();
	end
endmodule
`default_nettype wire
